// *** src/registered_bus_transceiver_18b.sv ***
`timescale 1ns/1ps
`include "xcvr_map.svh"
module registered_bus_transceiver_18b
	import xcvr_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// card-to-backplane controls
	input  wire logic        card_to_bp_out_en_n,
	input  wire logic        card_to_bp_clk_en_n,
	input  wire logic        card_to_bp_latch_en,
	input  wire logic        card_to_bp_clk,
	// backplane-to-card controls
	input  wire logic        bp_to_card_out_en_n,
	input  wire logic        bp_to_card_clk_en_n,
	input  wire logic        bp_to_card_latch_en,
	input  wire logic        bp_to_card_clk,
	// card-side pins, three-state
	input  wire lane_type    card_side_data_in,
	output lane_type         card_side_data_out,
	output lane_type         card_side_data_oe_n,
	// backplane-side pins, open drain
	input  wire lane_type    backplane_side_data_in,
	output lane_type         backplane_side_data_out,
	output lane_type         backplane_side_data_oe_n
);

	xcvr_path_if   c2b ();
	xcvr_path_if   b2c ();
	bus_state_type bus_r;
	bus_state_type bus_nxt;
	logic          addr_take;
	logic          conflict;
	logic          card_drive;

	////////////////////////////////////////////////////////////////
	// both directions share one storage module shape
	assign c2b.d_in     = card_side_data_in;
	assign c2b.latch_en = card_to_bp_latch_en;
	assign c2b.clk      = card_to_bp_clk;
	assign c2b.clk_en_n = card_to_bp_clk_en_n;
	assign c2b.out_en_n = card_to_bp_out_en_n;

	assign b2c.d_in     = backplane_side_data_in;
	assign b2c.latch_en = bp_to_card_latch_en;
	assign b2c.clk      = bp_to_card_clk;
	assign b2c.clk_en_n = bp_to_card_clk_en_n;
	assign b2c.out_en_n = bp_to_card_out_en_n;

	xcvr_path_store u_c2b_store (
		.hclk    (hclk),
		.hresetn (hresetn),
		.p       (c2b.path)
	);

	xcvr_path_store u_b2c_store (
		.hclk    (hclk),
		.hresetn (hresetn),
		.p       (b2c.path)
	);

	////////////////////////////////////////////////////////////////
	// pins
	assign conflict   = c2b.drive & b2c.drive;
	// guard is optional: with both enabled the card side backs off
	assign card_drive = b2c.drive & ~(bus_r.guard & conflict);

	// open drain: driven pin only ever goes low, a one releases it
	assign backplane_side_data_out  = `STORE_RESET;
	assign backplane_side_data_oe_n = c2b.drive ? c2b.q : {`XCVR_LANES{1'b1}};

	// three-state card outputs
	assign card_side_data_out  = b2c.q;
	assign card_side_data_oe_n = {`XCVR_LANES{~card_drive}};

	////////////////////////////////////////////////////////////////
	// register bus, zero wait states, unmapped reads give zero
	function automatic logic [31:0] read_word(input logic [7:0] ofs);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (ofs)
			`REG_CTRL_OFS:     w[`CTRL_GUARD_BIT] = bus_r.guard;
			`REG_C2B_DATA_OFS: w[`XCVR_LANES-1:0] = c2b.q;
			`REG_B2C_DATA_OFS: w[`XCVR_LANES-1:0] = b2c.q;
			`REG_STATUS_OFS:
			begin
				w[`ST_C2B_TRANSP_BIT] = c2b.transp;
				w[`ST_C2B_FLOP_BIT]   = c2b.sel_flop;
				w[`ST_B2C_TRANSP_BIT] = b2c.transp;
				w[`ST_B2C_FLOP_BIT]   = b2c.sel_flop;
				w[`ST_C2B_DRIVE_BIT]  = c2b.drive;
				w[`ST_B2C_DRIVE_BIT]  = b2c.drive;
				w[`ST_CONFLICT_BIT]   = conflict;
			end
			default:           w = 32'h00000000;
		endcase
		return w;
	endfunction : read_word

	assign addr_take = hsel & htrans[1] & hready;

	always_comb
	begin
		bus_nxt = bus_r;
		if (bus_r.wr_pend && bus_r.addr == `REG_CTRL_OFS)
		begin
			bus_nxt.guard = hwdata[`CTRL_GUARD_BIT];
		end
		bus_nxt.wr_pend = addr_take & hwrite;
		if (addr_take)
		begin
			bus_nxt.addr = {haddr[7:2], 2'b00};
			if (!hwrite)
			begin
				// sampled at the address phase so the data phase needs no wait
				bus_nxt.rdata = read_word({haddr[7:2], 2'b00});
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_r <= '{addr: 8'h00, wr_pend: 1'b0, rdata: 32'h00000000, guard: `CTRL_RESET};
		end
		else
		begin
			bus_r <= bus_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = bus_r.rdata;

	////////////////////////////////////////////////////////////////
	// one clock domain, so every check below shares the bus clock and reset
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// clock pins are sampled, so an edge is high now and low one sample ago
	sequence c2b_capture_s;
		!card_to_bp_latch_en && !card_to_bp_clk_en_n && card_to_bp_clk && !$past(card_to_bp_clk) ##1 !card_to_bp_latch_en;
	endsequence

	sequence b2c_capture_s;
		!bp_to_card_latch_en && !bp_to_card_clk_en_n && bp_to_card_clk && !$past(bp_to_card_clk) ##1 !bp_to_card_latch_en;
	endsequence

	sequence c2b_inhibit_s;
		!card_to_bp_latch_en && card_to_bp_clk_en_n ##1 !card_to_bp_latch_en;
	endsequence

	sequence b2c_inhibit_s;
		!bp_to_card_latch_en && bp_to_card_clk_en_n ##1 !bp_to_card_latch_en;
	endsequence

	sequence c2b_close_s;
		card_to_bp_latch_en ##1 !card_to_bp_latch_en;
	endsequence

	sequence b2c_close_s;
		bp_to_card_latch_en ##1 !bp_to_card_latch_en;
	endsequence

	// read taken at the address edge, data phase one cycle later
	sequence rd_s(logic [5:0] idx);
		hsel && htrans[1] && hready && !hwrite && haddr[7:2] == idx ##1 1'b1;
	endsequence

	sequence wr_s(logic [5:0] idx);
		hsel && htrans[1] && hready && hwrite && haddr[7:2] == idx ##1 1'b1;
	endsequence

	sequence rd_hole_s;
		hsel && htrans[1] && hready && !hwrite && haddr[7:2] > 6'h03 ##1 1'b1;
	endsequence

	// bus handshake never stalls or errors
	AST_HREADYOUT: assert property (hreadyout)
		else $error("slave inserted a wait state");

	AST_HRESP_OKAY: assert property (!hresp)
		else $error("slave answered with an error");

	// pins
	AST_OD_OUT_LOW: assert property (backplane_side_data_out == '0)
		else $error("open-drain data is not low");

	AST_OD_STORE: assert property (!card_to_bp_out_en_n |-> backplane_side_data_oe_n == c2b.q)
		else $error("backplane pull does not follow stored data");

	AST_CARD_OE_EQUAL: assert property (card_side_data_oe_n == {`XCVR_LANES{card_side_data_oe_n[0]}})
		else $error("card enables differ between lanes");

	AST_CARD_OE_ON: assert property (!bp_to_card_out_en_n && !(bus_r.guard && conflict) |-> card_side_data_oe_n == '0)
		else $error("card pins not driven while enabled");

	// guard only ever releases, it never adds a driver
	AST_GUARD_BACKOFF: assert property (bus_r.guard && conflict |-> &card_side_data_oe_n)
		else $error("card side drove against the backplane side");

	AST_CARD_OUT_STORE: assert property (card_side_data_out == b2c.q)
		else $error("card output is not the selected data");

	AST_B2C_TRANSPARENT: assert property (bp_to_card_latch_en |-> card_side_data_out == backplane_side_data_in)
		else $error("card output not transparent");

	AST_C2B_TRANSP_Q: assert property (card_to_bp_latch_en |-> c2b.q == card_side_data_in)
		else $error("backplane value not transparent");

	// storage, per direction
	AST_C2B_CAPTURE: assert property (c2b_capture_s |-> c2b.q == $past(card_side_data_in))
		else $error("card data not captured on clock edge");

	AST_B2C_CAPTURE: assert property (b2c_capture_s |-> b2c.q == $past(backplane_side_data_in))
		else $error("backplane data not captured on clock edge");

	AST_C2B_HOLD: assert property (c2b_inhibit_s |-> $stable(c2b.q))
		else $error("card-to-backplane value moved while inhibited");

	AST_B2C_HOLD: assert property (b2c_inhibit_s |-> $stable(b2c.q))
		else $error("backplane-to-card value moved while inhibited");

	AST_C2B_CLOSE: assert property (c2b_close_s |-> c2b.q == $past(card_side_data_in))
		else $error("card-to-backplane latch lost data at closing");

	AST_B2C_CLOSE: assert property (b2c_close_s |-> b2c.q == $past(backplane_side_data_in))
		else $error("backplane-to-card latch lost data at closing");

	AST_C2B_FLOP_SEL: assert property (c2b_capture_s |-> c2b.sel_flop)
		else $error("card-to-backplane flop not selected after capture");

	AST_B2C_FLOP_SEL: assert property (b2c_capture_s |-> b2c.sel_flop)
		else $error("backplane-to-card flop not selected after capture");

	AST_C2B_LATCH_SEL: assert property (card_to_bp_latch_en |=> !c2b.sel_flop)
		else $error("card-to-backplane latch not selected");

	AST_B2C_LATCH_SEL: assert property (bp_to_card_latch_en |=> !b2c.sel_flop)
		else $error("backplane-to-card latch not selected");

	// status flags mirror the pins, no delay
	AST_C2B_TRANSP_FLAG: assert property (c2b.transp == card_to_bp_latch_en)
		else $error("transparent flag wrong");

	AST_C2B_DRIVE_FLAG: assert property (c2b.drive == !card_to_bp_out_en_n)
		else $error("card-to-backplane drive flag wrong");

	AST_B2C_DRIVE_FLAG: assert property (b2c.drive == !bp_to_card_out_en_n)
		else $error("backplane-to-card drive flag wrong");

	AST_CONFLICT_FLAG: assert property (conflict == (!card_to_bp_out_en_n && !bp_to_card_out_en_n))
		else $error("conflict flag wrong");

	// register reads, value sampled at the address edge
	AST_RD_CTRL: assert property (rd_s(6'h00) |-> hrdata == {31'h0, $past(bus_r.guard)})
		else $error("control read wrong");

	AST_RD_C2B: assert property (rd_s(6'h01) |-> hrdata == {14'h0, $past(c2b.q)})
		else $error("card-to-backplane value read wrong");

	AST_RD_B2C: assert property (rd_s(6'h02) |-> hrdata == {14'h0, $past(b2c.q)})
		else $error("backplane-to-card value read wrong");

	AST_RD_STATUS: assert property (rd_s(6'h03) |-> hrdata == {25'h0, $past(conflict),
		$past(b2c.drive), $past(c2b.drive), $past(b2c.sel_flop), $past(b2c.transp),
		$past(c2b.sel_flop), $past(c2b.transp)})
		else $error("status read wrong");

	AST_RD_HOLE: assert property (rd_hole_s |-> hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	// read data stands until the next read is taken
	AST_RD_STANDS: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");

	AST_CTRL_WRITE: assert property (wr_s(6'h00) |=> bus_r.guard == $past(hwdata[`CTRL_GUARD_BIT]))
		else $error("guard write did not land");

	AST_GUARD_KEEP: assert property (!bus_r.wr_pend |=> $stable(bus_r.guard))
		else $error("guard changed without a write");

	////////////////////////////////////////////////////////////////
	AST_OD_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
		card_to_bp_out_en_n |-> &backplane_side_data_oe_n)
		else $error("backplane pin pulled while disabled");

	AST_OD_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
		!card_to_bp_out_en_n && card_to_bp_latch_en |->
		backplane_side_data_oe_n == card_side_data_in && backplane_side_data_out == `STORE_RESET)
		else $error("open-drain level does not match card data");

	AST_A_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
		bp_to_card_out_en_n |-> &card_side_data_oe_n)
		else $error("card pins driven while disabled");

	AST_A_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
		!bp_to_card_out_en_n && card_to_bp_out_en_n && bp_to_card_latch_en |->
		card_side_data_oe_n == `STORE_RESET && card_side_data_out == backplane_side_data_in)
		else $error("card pins not driving backplane data");

endmodule : registered_bus_transceiver_18b

// *** src/xcvr_map.svh ***
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH

// lane count
`define XCVR_LANES        18

// register byte offsets, one aligned word each
`define REG_CTRL_OFS      8'h00
`define REG_C2B_DATA_OFS  8'h04
`define REG_B2C_DATA_OFS  8'h08
`define REG_STATUS_OFS    8'h0C

// control register fields and reset value
`define CTRL_GUARD_BIT    0
`define CTRL_RESET        1'b0

// status register fields
`define ST_C2B_TRANSP_BIT 0
`define ST_C2B_FLOP_BIT   1
`define ST_B2C_TRANSP_BIT 2
`define ST_B2C_FLOP_BIT   3
`define ST_C2B_DRIVE_BIT  4
`define ST_B2C_DRIVE_BIT  5
`define ST_CONFLICT_BIT   6

// storage reset value
`define STORE_RESET       18'h00000

`endif

// *** src/xcvr_path_if.sv ***
`timescale 1ns/1ps
interface xcvr_path_if;
	import xcvr_pkg::*;
	lane_type d_in;
	logic     latch_en;
	logic     clk;
	logic     clk_en_n;
	logic     out_en_n;
	lane_type q;
	logic     drive;
	logic     transp;
	logic     sel_flop;

	modport path (input d_in, latch_en, clk, clk_en_n, out_en_n, output q, drive, transp, sel_flop);
	modport top  (output d_in, latch_en, clk, clk_en_n, out_en_n, input q, drive, transp, sel_flop);
endinterface : xcvr_path_if

// *** src/xcvr_path_store.sv ***
`timescale 1ns/1ps
`include "xcvr_map.svh"
module xcvr_path_store
	import xcvr_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// one direction of the transceiver
	xcvr_path_if.path p
);

	path_state_type st_r;
	path_state_type st_nxt;
	logic           clk_rise;

	////////////////////////////////////////////////////////////////
	assign clk_rise = p.clk & ~st_r.clk_prev;

	always_comb
	begin
		st_nxt          = st_r;
		st_nxt.clk_prev = p.clk;
		if (p.latch_en)
		begin
			// level latch tracks while open; closing keeps the last value
			st_nxt.latch    = p.d_in;
			st_nxt.sel_flop = 1'b0;
		end
		else if (clk_rise && !p.clk_en_n)
		begin
			st_nxt.flop     = p.d_in;
			st_nxt.sel_flop = 1'b1;
		end
		// clock enable high: edges ignored, storage holds
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= '{latch: `STORE_RESET, flop: `STORE_RESET, sel_flop: 1'b0, clk_prev: 1'b0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// transparent path bypasses storage, ahead of clock and enable
	assign p.q        = p.latch_en ? p.d_in : (st_r.sel_flop ? st_r.flop : st_r.latch);
	assign p.drive    = ~p.out_en_n;
	assign p.transp   = p.latch_en;
	assign p.sel_flop = st_r.sel_flop;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence capture_s;
		!p.latch_en && !p.clk_en_n && clk_rise ##1 !p.latch_en;
	endsequence

	sequence inhibit_s;
		!p.latch_en && p.clk_en_n ##1 !p.latch_en;
	endsequence

	AST_TRANSPARENT: assert property (p.latch_en |-> p.q == p.d_in)
		else $error("transparent output differs from input");

	AST_CLOCKED: assert property (capture_s |-> p.q == $past(p.d_in))
		else $error("clocked data not captured on rising edge");

	AST_INHIBIT: assert property (inhibit_s |-> $stable(p.q))
		else $error("stored value changed while clock inhibited");

	AST_LATCH_HOLD: assert property ($fell(p.latch_en) |-> p.q == $past(p.d_in))
		else $error("latch did not keep data at closing");

endmodule : xcvr_path_store

// *** src/xcvr_pkg.sv ***
package xcvr_pkg;
	`include "xcvr_map.svh"

	typedef logic [`XCVR_LANES-1:0] lane_type;

	typedef struct packed {
		lane_type latch;
		lane_type flop;
		logic     sel_flop;
		logic     clk_prev;
	} path_state_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic        wr_pend;
		logic [31:0] rdata;
		logic        guard;
	} bus_state_type;
endpackage : xcvr_pkg

// *** testbench/registered_bus_transceiver_18b_test.sv ***
`timescale 1ns/1ps
module registered_bus_transceiver_18b_test;
	import xcvr_pkg::*;

	typedef struct packed {logic [2:0] kind; logic [31:0] val;} note_type;
	logic        hclk, hresetn, hsel, hwrite, hreadyout;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0]  ctl [2];
	lane_type    card_drive, bp_drive, card_in, card_out, card_oe_n, bp_in, bp_oe_n, d1, d2, d3;
	note_type    exp_q [$];
	note_type    nt;
	integer      seed = 32'hF38D;
	int          n_fail = 0;
	int          checked = 0;
	string       nm [5] = '{"bp wire", "card wire", "hrdata", "bp oe_n", "card oe_n"};

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	registered_bus_transceiver_18b u_registered_bus_transceiver_18b (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.card_to_bp_out_en_n(ctl[0][3]), .card_to_bp_clk_en_n(ctl[0][2]),
		.card_to_bp_latch_en(ctl[0][1]), .card_to_bp_clk(ctl[0][0]),
		.bp_to_card_out_en_n(ctl[1][3]), .bp_to_card_clk_en_n(ctl[1][2]),
		.bp_to_card_latch_en(ctl[1][1]), .bp_to_card_clk(ctl[1][0]),
		.card_side_data_in(card_in), .card_side_data_out(card_out), .card_side_data_oe_n(card_oe_n),
		.backplane_side_data_in(bp_in), .backplane_side_data_out(), .backplane_side_data_oe_n(bp_oe_n));

	xcvr_partner u_xcvr_partner (
		.card_side_data_out(card_out), .card_side_data_oe_n(card_oe_n),
		.backplane_side_data_oe_n(bp_oe_n), .card_drive(card_drive), .bp_drive(bp_drive),
		.card_side_data_in(card_in), .backplane_side_data_in(bp_in));

	////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checked %0d, failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task expect_val(input logic [2:0] kind, input logic [31:0] val);
		exp_q.push_back('{kind, val});
	endtask : expect_val

	function automatic logic [31:0] observe(input logic [2:0] kind);
		case (kind)
			3'h0: return {14'h0, bp_in};
			3'h1: return {14'h0, card_in};
			3'h2: return hrdata;
			3'h3: return {14'h0, bp_oe_n};
			default: return {14'h0, card_oe_n};
		endcase
	endfunction : observe

	// mid-cycle sampling keeps the compare clear of the launching edge
	always @(negedge hclk)
		if (exp_q.size() > 0)
		begin
			nt = exp_q.pop_front();
			check(nm[nt.kind], observe(nt.kind), nt.val);
		end

	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		if (!wr)
			expect_val(3'h2, ex);
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : ahb

	// ctl is {out_en_n, clk_en_n, latch_en, clk}
	task step(input int d, input logic [3:0] c, input lane_type v);
		@(posedge hclk);
		ctl[d] <= c;
		if (d == 0)
			card_drive <= v;
		else
			bp_drive <= v;
	endtask : step

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		n_fail++;
		print_verdict;
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ctl[0] = 4'h8;
		ctl[1] = 4'h8;
		card_drive = 18'h0;
		bp_drive = 18'h3FFFF;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 8'h00, 32'h0, 32'h0);
		ahb(1'b0, 8'h04, 32'h0, 32'h0);
		ahb(1'b0, 8'h10, 32'h0, 32'h0);
		for (int d = 0; d < 2; d++)
		begin
			d1 = 18'($random(seed));
			d2 = 18'($random(seed));
			d3 = 18'($random(seed));
			step(d, 4'h2, d1);
			expect_val(3'(d), {14'h0, d1});
			if (d == 0)
				ahb(1'b0, 8'h0C, 32'h0, 32'h11);
			step(d, 4'h0, d2);
			expect_val(3'(d), {14'h0, d1});
			step(d, 4'h1, d3);
			step(d, 4'h0, d2);
			expect_val(3'(d), {14'h0, d3});
			ahb(1'b0, d ? 8'h08 : 8'h04, 32'h0, {14'h0, d3});
			step(d, 4'h4, d1);
			step(d, 4'h5, d1);
			step(d, 4'h4, d1);
			expect_val(3'(d), {14'h0, d3});
			step(d, 4'hC, d1);
			expect_val(3'(d + 3), 32'h3FFFF);
		end
		// guard set on purpose before both directions are enabled together
		ahb(1'b1, 8'h00, 32'h1, 32'h0);
		ahb(1'b0, 8'h00, 32'h0, 32'h1);
		step(0, 4'h2, d1);
		step(1, 4'h2, d2);
		expect_val(3'h4, 32'h3FFFF);
		repeat (2) @(posedge hclk);
		print_verdict;
	end
endmodule : registered_bus_transceiver_18b_test

// *** testbench/xcvr_partner.sv ***
`timescale 1ns/1ps
module xcvr_partner
	import xcvr_pkg::*;
(
	// device pins
	input  wire lane_type card_side_data_out,
	input  wire lane_type card_side_data_oe_n,
	input  wire lane_type backplane_side_data_oe_n,
	// far-side drivers, 1 on bp_drive means released
	input  wire lane_type card_drive,
	input  wire lane_type bp_drive,
	// resolved wires
	output lane_type      card_side_data_in,
	output lane_type      backplane_side_data_in
);
	// card logic drives only while the device floats its pins, never both at once
	assign card_side_data_in = (card_side_data_oe_n & card_drive)
		| (~card_side_data_oe_n & card_side_data_out);
	// pull-up on the backplane, any party may pull a lane low
	assign backplane_side_data_in = backplane_side_data_oe_n & bp_drive;
endmodule : xcvr_partner
